// File: hdl/sbg_pkg.sv
// Shared constants, types and register layout of the serial baud rate generator.
package sbg_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam int SBG_ADDR_W = 2;
    localparam logic [SBG_ADDR_W-1:0] SBG_OFF_TXSC = 2'h0;
    localparam logic [SBG_ADDR_W-1:0] SBG_OFF_RXSC = 2'h1;
    localparam logic [SBG_ADDR_W-1:0] SBG_OFF_DIV = 2'h2;

    // ----------------------------------------------------------------
    // Field positions of tx_status_control
    // ----------------------------------------------------------------
    localparam int SBG_TX_CLOCK_SOURCE_SELECT = 7;
    localparam int SBG_TX_TX9 = 6;
    localparam int SBG_TX_TXEN = 5;
    localparam int SBG_TX_SYNC = 4;
    localparam int SBG_TX_HIGH_SPEED_SELECT = 2;
    localparam int SBG_TX_TRMT = 1;
    localparam int SBG_TX_TX9D = 0;

    // ----------------------------------------------------------------
    // Field positions of rx_status_control
    // ----------------------------------------------------------------
    localparam int SBG_RX_PORT_ENABLE_BIT = 7;
    localparam int SBG_RX_RX9 = 6;
    localparam int SBG_RX_SREN = 5;
    localparam int SBG_RX_CREN = 4;
    localparam int SBG_RX_ADDEN = 3;
    localparam int SBG_RX_FERR = 2;
    localparam int SBG_RX_OERR = 1;
    localparam int SBG_RX_RX9D = 0;

    // ----------------------------------------------------------------
    // Writable masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] SBG_TXSC_WMASK = 8'hf5;
    localparam logic [7:0] SBG_RXSC_WMASK = 8'hf8;
    localparam logic [7:0] SBG_TXSC_RST = 8'h00;
    localparam logic [7:0] SBG_RXSC_RST = 8'h00;
    localparam logic [7:0] SBG_DIV_RST = 8'h00;
    localparam logic [2:0] SBG_SAMPLE_RST = 3'h7;

    // ----------------------------------------------------------------
    // Prescale terminal counts: bit rate is timer tick over 64, 16 or 4
    // ----------------------------------------------------------------
    localparam logic [5:0] SBG_PSC_LAST_LO = 6'h3f;
    localparam logic [5:0] SBG_PSC_LAST_HI = 6'h0f;
    localparam logic [5:0] SBG_PSC_LAST_SYNC = 6'h03;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        SBG_MODE_OFF = 5'h01,
        SBG_MODE_ASYNC_LO = 5'h02,
        SBG_MODE_ASYNC_HI = 5'h04,
        SBG_MODE_SYNC_M = 5'h08,
        SBG_MODE_SYNC_S = 5'h10
    } sbg_mode_e;

    typedef struct packed {
        logic port_en;
        logic sync_mode;
        logic master;
        logic high_speed;
        logic tx9;
        logic tx_en;
        logic tx9d;
        logic rx9;
        logic single_rx;
        logic cont_rx;
        logic addr_det;
    } sbg_cfg_s;

    typedef struct packed {
        logic framing_err;
        logic overrun_err;
        logic rx9d;
    } sbg_rx_stat_s;

endpackage : sbg_pkg

// File: hdl/sbg_majority.sv
// Receive pin synchroniser with three-sample majority vote.
`timescale 1ns/1ps
`default_nettype none
module sbg_majority
    import sbg_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic pin_in, // Raw receive pin.
    input wire logic sample_en, // Take one sample this cycle.
    output logic level // Voted pin level.
);

    logic sync1_ff;
    logic sync2_ff;
    logic [2:0] samples_ff;
    logic level_ff;
    logic [2:0] nxt_samples;
    logic nxt_level;

    // ----------------------------------------------------------------
    // Synchroniser
    // ----------------------------------------------------------------
    // The pin is asynchronous; only the second stage is read further on.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    // ----------------------------------------------------------------
    // Vote
    // ----------------------------------------------------------------
    // R9 three-sample majority
    assign nxt_samples = sample_en ? {samples_ff[1:0], sync2_ff} : samples_ff;
    assign nxt_level = (samples_ff[0] & samples_ff[1]) | (samples_ff[0] & samples_ff[2]) |
        (samples_ff[1] & samples_ff[2]);

    // Idle line is high, so the history starts high to avoid a false start bit.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            samples_ff <= SBG_SAMPLE_RST;
            level_ff <= 1'b1;
        end else begin
            samples_ff <= nxt_samples;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;

    AST_MAJ_VOTE: assert property (@(posedge clk) disable iff (reset) // R9
        (samples_ff == 3'h0) |=> !level_ff) else $error("vote missed a low majority");

endmodule : sbg_majority
`default_nettype wire

// File: hdl/sbg_top.sv
// Baud rate generator, mode decode and receive sampler of the serial port.
//
// Function
// R1 - One dedicated 8-bit timer generates the rate for both asynchronous and synchronous modes.
// R2 - The timer runs freely with its period set by the software-written divisor.
// R3 - In asynchronous mode the high-speed select bit changes the rate as well as the divisor.
// R4 - In synchronous mode the high-speed select bit is ignored.
// R5 - Bit rate is clock over 64(n+1), 16(n+1) async low/high, or 4(n+1) synchronous.
// R6 - The rate formulas apply only as master; a synchronous slave gets no generated ticks.
// R7 - Any write to the divisor clears the timer at once.
// R8 - Timing derives from the system clock, so software rewrites the divisor after a change.
// R9 - The receive pin is sampled three times and a majority vote gives its level.
// R10 - Mode select clear means asynchronous, set means synchronous.
// R11 - In asynchronous mode the timer output is 16 or 64 times the bit rate.
// R12 - In synchronous mode clock source select set means master, clear means slave.
// R13 - The timer ticks every n+1 clocks and reloads; a prescaler then divides those ticks.
// R14 - With the port enable bit clear the timer is held cleared and no ticks appear.
`timescale 1ns/1ps
`default_nettype none
module sbg_top
    import sbg_pkg::*;
(
    input wire logic clk, // System clock, 250 MHz.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic [SBG_ADDR_W-1:0] addr, // Register address.
    input wire logic [7:0] wr_data, // Write data.
    input wire logic wr_en, // Write strobe.
    input wire logic rd_en, // Read strobe.
    output logic [7:0] rd_data, // Read data, one cycle after rd_en.
    input wire logic tx_shift_empty, // Transmit shift register is empty.
    input wire sbg_rx_stat_s rx_stat, // Receiver error and ninth bit.
    input wire logic rx_single_done, // Pulse: single receive finished.
    input wire logic serial_receive_pin, // Raw receive pin.
    output logic rx_level, // Voted receive level.
    output logic ovs_tick, // Pulse: timer tick, the oversample clock.
    output logic bit_tick, // Pulse: one bit period elapsed.
    output sbg_cfg_s cfg // Decoded port configuration.
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] txsc_ff;
    logic [7:0] rxsc_ff;
    logic [7:0] div_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] cnt_ff;
    logic [5:0] psc_ff;
    logic ovs_tick_ff;
    logic bit_tick_ff;
    sbg_mode_e mode_ff;
    sbg_cfg_s cfg_ff;

    logic [7:0] nxt_txsc;
    logic [7:0] nxt_rxsc;
    logic [7:0] nxt_div;
    logic [7:0] nxt_rd_data;
    logic [7:0] nxt_cnt;
    logic [5:0] nxt_psc;
    logic nxt_ovs_tick;
    logic nxt_bit_tick;
    sbg_mode_e nxt_mode;
    sbg_cfg_s nxt_cfg;

    logic wr_txsc;
    logic wr_rxsc;
    logic wr_div;
    logic port_en_bit;
    logic mode_select;
    logic high_speed_select;
    logic clock_source_select;
    logic [7:0] txsc_view;
    logic [7:0] rxsc_view;
    logic timer_run;
    logic timer_wrap;
    logic [5:0] psc_last;
    logic psc_wrap;
    logic sren_clr;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    // Writes to the spare offset are dropped; reads of it return zero.
    assign wr_txsc = wr_en && (addr == SBG_OFF_TXSC);
    assign wr_rxsc = wr_en && (addr == SBG_OFF_RXSC);
    assign wr_div = wr_en && (addr == SBG_OFF_DIV);

    assign port_en_bit = rxsc_ff[SBG_RX_PORT_ENABLE_BIT];
    assign mode_select = txsc_ff[SBG_TX_SYNC];
    assign high_speed_select = txsc_ff[SBG_TX_HIGH_SPEED_SELECT];
    assign clock_source_select = txsc_ff[SBG_TX_CLOCK_SOURCE_SELECT];

    // Status bits from the shift logic are merged in on the read path only.
    assign txsc_view = (txsc_ff & SBG_TXSC_WMASK) | {6'h00, tx_shift_empty, 1'b0};
    assign rxsc_view = (rxsc_ff & SBG_RXSC_WMASK) |
        {5'h00, rx_stat.framing_err, rx_stat.overrun_err, rx_stat.rx9d};

    assign nxt_rd_data = !rd_en ? 8'h00 :
        (addr == SBG_OFF_TXSC) ? txsc_view :
        (addr == SBG_OFF_RXSC) ? rxsc_view :
        (addr == SBG_OFF_DIV) ? div_ff : 8'h00;

    // ----------------------------------------------------------------
    // Register next values
    // ----------------------------------------------------------------
    assign nxt_txsc = wr_txsc ? (wr_data & SBG_TXSC_WMASK) : txsc_ff;
    // The receiver clears single receive when done; a software write in
    // the same cycle wins so a fresh request is never lost.
    assign sren_clr = rx_single_done && !wr_rxsc;
    assign nxt_rxsc = wr_rxsc ? (wr_data & SBG_RXSC_WMASK) :
        (sren_clr ? (rxsc_ff & ~(8'h01 << SBG_RX_SREN)) : rxsc_ff);
    assign nxt_div = wr_div ? wr_data : div_ff;

    // Registers, divisor and read data.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txsc_ff <= SBG_TXSC_RST;
            rxsc_ff <= SBG_RXSC_RST;
            div_ff <= SBG_DIV_RST;
            rd_data_ff <= 8'h00;
        end else begin
            txsc_ff <= nxt_txsc;
            rxsc_ff <= nxt_rxsc;
            div_ff <= nxt_div;
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // R10 async or sync
    // R12 master or slave
    always_comb begin
        if (!port_en_bit) begin
            nxt_mode = SBG_MODE_OFF;
        end else if (!mode_select) begin
            nxt_mode = high_speed_select ? SBG_MODE_ASYNC_HI : SBG_MODE_ASYNC_LO;
        end else if (clock_source_select) begin
            nxt_mode = SBG_MODE_SYNC_M;
        end else begin
            nxt_mode = SBG_MODE_SYNC_S;
        end
    end

    // R3 speed select prescale
    // R4 sync ignores speed
    // R11 oversample ratio
    always_comb begin
        case (mode_ff)
            SBG_MODE_ASYNC_LO: begin
                psc_last = SBG_PSC_LAST_LO;
            end
            SBG_MODE_ASYNC_HI: begin
                psc_last = SBG_PSC_LAST_HI;
            end
            SBG_MODE_SYNC_M: begin
                psc_last = SBG_PSC_LAST_SYNC;
            end
            default: begin
                psc_last = SBG_PSC_LAST_SYNC;
            end
        endcase
    end

    // R6 slave takes no ticks
    // R14 disabled port holds timer
    assign timer_run = (mode_ff == SBG_MODE_ASYNC_LO) || (mode_ff == SBG_MODE_ASYNC_HI) ||
        (mode_ff == SBG_MODE_SYNC_M);

    // ----------------------------------------------------------------
    // Baud timer
    // ----------------------------------------------------------------
    // R1 shared 8-bit timer
    // R2 free-running period
    // R8 counts system clocks
    // R13 wrap every n+1
    assign timer_wrap = timer_run && (cnt_ff == div_ff);
    assign psc_wrap = timer_wrap && (psc_ff >= psc_last);

    // R7 write clears timer
    // A mode change also restarts the count so the first bit is never short.
    assign nxt_cnt = (wr_div || !timer_run || (nxt_mode != mode_ff)) ? 8'h00 :
        (timer_wrap ? 8'h00 : cnt_ff + 8'h01);
    assign nxt_psc = (wr_div || !timer_run || (nxt_mode != mode_ff)) ? 6'h00 :
        (psc_wrap ? 6'h00 : (timer_wrap ? psc_ff + 6'h01 : psc_ff));

    // R5 rate formulas
    assign nxt_ovs_tick = timer_wrap && !wr_div;
    assign nxt_bit_tick = psc_wrap && !wr_div;

    // Timer, prescaler and tick flops.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_ff <= SBG_MODE_OFF;
            cnt_ff <= 8'h00;
            psc_ff <= 6'h00;
            ovs_tick_ff <= 1'b0;
            bit_tick_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            cnt_ff <= nxt_cnt;
            psc_ff <= nxt_psc;
            ovs_tick_ff <= nxt_ovs_tick;
            bit_tick_ff <= nxt_bit_tick;
        end
    end

    // ----------------------------------------------------------------
    // Configuration out
    // ----------------------------------------------------------------
    // Downstream shift logic sees a registered copy; this costs one cycle of
    // latency after a register write but keeps its timing paths short.
    assign nxt_cfg = '{
        port_en: port_en_bit,
        sync_mode: mode_select,
        master: clock_source_select,
        high_speed: high_speed_select,
        tx9: txsc_ff[SBG_TX_TX9],
        tx_en: txsc_ff[SBG_TX_TXEN],
        tx9d: txsc_ff[SBG_TX_TX9D],
        rx9: rxsc_ff[SBG_RX_RX9],
        single_rx: rxsc_ff[SBG_RX_SREN],
        cont_rx: rxsc_ff[SBG_RX_CREN],
        addr_det: rxsc_ff[SBG_RX_ADDEN]
    };

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ----------------------------------------------------------------
    // Receive sampler
    // ----------------------------------------------------------------
    // R9 sample on oversample ticks
    sbg_majority u_majority (
        .clk(clk),
        .reset(reset),
        .pin_in(serial_receive_pin),
        .sample_en(ovs_tick_ff),
        .level(rx_level)
    );

    assign rd_data = rd_data_ff;
    assign ovs_tick = ovs_tick_ff;
    assign bit_tick = bit_tick_ff;
    assign cfg = cfg_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_TIMER_BOUND: assert property (@(posedge clk) disable iff (reset) // R1
        (!$past(wr_div) && timer_run) |-> (cnt_ff <= div_ff))
        else $error("timer ran past the divisor");

    AST_FREE_RUN: assert property (@(posedge clk) disable iff (reset) // R2
        (timer_run && !wr_div && cnt_ff < div_ff && nxt_mode == mode_ff)
        |=> (cnt_ff == $past(cnt_ff) + 8'h01))
        else $error("timer failed to advance");

    AST_DIV_CLEAR: assert property (@(posedge clk) disable iff (reset) // R7
        wr_div |=> (cnt_ff == 8'h00 && psc_ff == 6'h00 && !ovs_tick_ff))
        else $error("divisor write did not clear the timer");

    AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (reset) // R13
        (timer_wrap && !wr_div && div_ff == 8'h02 && nxt_mode == mode_ff &&
        !$past(wr_div)) ##1 (!wr_div && nxt_mode == mode_ff) [*3] |=> ovs_tick_ff)
        else $error("tick period is not n+1");

    AST_BIT_DIV: assert property (@(posedge clk) disable iff (reset) // R5
        bit_tick_ff |-> (ovs_tick_ff && $past(psc_ff) == $past(psc_last)))
        else $error("bit tick off the prescale count");

    AST_HS_SYNC: assert property (@(posedge clk) disable iff (reset) // R4
        (mode_ff == SBG_MODE_SYNC_M) |-> (psc_ff <= SBG_PSC_LAST_SYNC))
        else $error("sync prescale uses the speed bit");

    AST_HS_ASYNC: assert property (@(posedge clk) disable iff (reset) // R3
        (mode_ff == SBG_MODE_ASYNC_HI) |-> (psc_ff <= SBG_PSC_LAST_HI))
        else $error("high speed prescale too long");

    AST_SLAVE_QUIET: assert property (@(posedge clk) disable iff (reset) // R6
        (mode_ff == SBG_MODE_SYNC_S) [*2] |-> (!ovs_tick_ff && !bit_tick_ff))
        else $error("slave mode produced ticks");

    AST_OFF_HOLD: assert property (@(posedge clk) disable iff (reset) // R14
        !port_en_bit [*3] |-> (cnt_ff == 8'h00 && !ovs_tick_ff))
        else $error("disabled port kept counting");

    AST_MODE_DEC: assert property (@(posedge clk) disable iff (reset) // R12
        (port_en_bit && mode_select && !clock_source_select)
        |=> (mode_ff == SBG_MODE_SYNC_S))
        else $error("slave mode not decoded");

    AST_ASYNC_DEC: assert property (@(posedge clk) disable iff (reset) // R10
        (port_en_bit && !mode_select && !high_speed_select)
        |=> (mode_ff == SBG_MODE_ASYNC_LO))
        else $error("async low mode not decoded");

    // Decode, load and prescale checks; a mode change never leaves a stale count.
    AST_HS_DEC: assert property (@(posedge clk) disable iff (reset) // R3
        (port_en_bit && !mode_select && high_speed_select) |=> (mode_ff == SBG_MODE_ASYNC_HI))
        else $error("async high mode not decoded");

    AST_SYNC_M_DEC: assert property (@(posedge clk) disable iff (reset) // R12
        (port_en_bit && mode_select && clock_source_select) |=> (mode_ff == SBG_MODE_SYNC_M))
        else $error("sync master mode not decoded");

    AST_HS_IGNORED: assert property (@(posedge clk) disable iff (reset) // R4
        (bit_tick_ff && $past(mode_ff) == SBG_MODE_SYNC_M)
        |-> ($past(psc_ff) == SBG_PSC_LAST_SYNC))
        else $error("sync bit period depends on the speed bit");

    AST_HI_BIT: assert property (@(posedge clk) disable iff (reset) // R3
        (bit_tick_ff && $past(mode_ff) == SBG_MODE_ASYNC_HI)
        |-> ($past(psc_ff) == SBG_PSC_LAST_HI))
        else $error("high speed bit period is not sixteen ticks");

    AST_LO_BIT: assert property (@(posedge clk) disable iff (reset) // R11
        (bit_tick_ff && $past(mode_ff) == SBG_MODE_ASYNC_LO)
        |-> ($past(psc_ff) == SBG_PSC_LAST_LO))
        else $error("low speed bit period is not sixty-four ticks");

    AST_OFF_DEC: assert property (@(posedge clk) disable iff (reset) // R14
        !port_en_bit |=> (mode_ff == SBG_MODE_OFF && psc_ff == 6'h00))
        else $error("disabled port not held off");

    AST_SLAVE_HOLD: assert property (@(posedge clk) disable iff (reset) // R6
        (mode_ff == SBG_MODE_SYNC_S) |=> (cnt_ff == 8'h00 && psc_ff == 6'h00))
        else $error("slave mode let the timer run");

    AST_TICK_GAP: assert property (@(posedge clk) disable iff (reset) // R13
        (ovs_tick_ff && div_ff != 8'h00) |=> !ovs_tick_ff)
        else $error("ticks closer than the divisor allows");

    AST_WRAP_RELOAD: assert property (@(posedge clk) disable iff (reset) // R13
        timer_wrap |=> (cnt_ff == 8'h00))
        else $error("timer did not reload at wrap");

    AST_TICK_SRC: assert property (@(posedge clk) disable iff (reset) // R5
        ovs_tick_ff |-> $past(timer_wrap))
        else $error("tick without a timer wrap");

    AST_DIV_LOAD: assert property (@(posedge clk) disable iff (reset) // R2
        wr_div |=> (div_ff == $past(wr_data)))
        else $error("divisor write not stored");

    AST_DIV_READ: assert property (@(posedge clk) disable iff (reset) // R2
        (rd_en && addr == SBG_OFF_DIV) |=> (rd_data_ff == $past(div_ff)))
        else $error("divisor read back wrong");

endmodule : sbg_top
`default_nettype wire

// File: tb/sbg_remote_dev.sv
// Model of the remote serial device that drives the receive line.
`timescale 1ns/1ps
`default_nettype none
module sbg_remote_dev #(
    parameter int LAG = 1 // Cycles from a level request to the line, 1 to 8.
) (
    input wire logic clk, // System clock.
    input wire logic level_req, // Level the remote transmitter wants on the line.
    output logic line // Receive line as seen at the port pin.
);
    // ----------------------------------------------------------------
    // Output stage
    // ----------------------------------------------------------------
    // The line idles high, so the delay stage starts full of ones.
    // A larger lag models a slow remote driver; glitches come only
    // from what the bench requests.
    logic [7:0] pipe_ff = 8'hff;

    always_ff @(posedge clk) begin
        pipe_ff <= {pipe_ff[6:0], level_req};
    end

    assign line = pipe_ff[LAG-1]; // Delayed line level.
endmodule : sbg_remote_dev
`default_nettype wire

// File: tb/sbg_top_tb.sv
// Self-checking testbench of the serial baud rate generator.
`timescale 1ns/1ps
`default_nettype none
module sbg_top_tb
    import sbg_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk;
    logic reset;
    logic [SBG_ADDR_W-1:0] addr;
    logic [7:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_data;
    logic tx_shift_empty;
    sbg_rx_stat_s rx_stat;
    logic rx_single_done;
    logic level_req;
    logic serial_receive_pin;
    logic rx_level;
    logic ovs_tick;
    logic bit_tick;
    sbg_cfg_s cfg;
    int mismatches;
    int comparisons;

    sbg_top uut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .tx_shift_empty(tx_shift_empty), .rx_stat(rx_stat),
        .rx_single_done(rx_single_done), .serial_receive_pin(serial_receive_pin),
        .rx_level(rx_level), .ovs_tick(ovs_tick), .bit_tick(bit_tick), .cfg(cfg));

    sbg_remote_dev #(.LAG(2)) remote (.clk(clk), .level_req(level_req),
        .line(serial_receive_pin));

    // 250 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // One-cycle write strobe; the second edge is the one that takes it.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, then return to zero.
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(16'(rd_data), 16'(exp));
        @(negedge clk);
        chk(16'(rd_data), 16'h0000);
    endtask : rd

    // Counts cycles up to and including the next tick of the chosen output.
    task automatic gap(input bit use_bit, output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (((use_bit ? bit_tick : ovs_tick) !== 1'b1) && k < 4000);
    endtask : gap

    // Counts cycles with any tick over a fixed span.
    task automatic no_ticks;
        int cnt;
        cnt = 0;
        repeat (600) begin
            @(negedge clk);
            if (ovs_tick !== 1'b0 || bit_tick !== 1'b0) cnt++;
        end
        chk(16'(cnt), 16'h0000);
    endtask : no_ticks

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset values, read-only bits, unmapped address and decoded config.
    task automatic test_regs;
        @(negedge clk);
        chk(16'(rx_level), 16'h0001);
        chk(16'(cfg), 16'h0000);
        rd(2'h0, 8'h02);
        rd(2'h1, 8'h05);
        rd(2'h2, 8'h00);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'hff);
        wr(2'h1, 8'hff);
        wr(2'h2, 8'ha5);
        rd(2'h0, 8'hf7);
        rd(2'h1, 8'hfd);
        rd(2'h2, 8'ha5);
        chk(16'(cfg), 16'h07ff);
        @(posedge clk);
        rx_single_done <= 1'b1;
        @(posedge clk);
        rx_single_done <= 1'b0;
        rd(2'h1, 8'hdd);
    endtask : test_regs

    // Tick spacing for one mode; a zero expectation means no ticks at all.
    task automatic rate_case(input logic [7:0] txc, input logic [7:0] n,
        input int ovs_exp, input int bit_exp);
        int k;
        wr(2'h1, 8'h80);
        wr(2'h0, txc);
        wr(2'h2, n);
        if (ovs_exp == 0) begin
            no_ticks();
        end else begin
            gap(1'b0, k);
            gap(1'b0, k);
            chk(16'(k), 16'(ovs_exp));
            gap(1'b1, k);
            chk(16'(ovs_tick), 16'h0001);
            gap(1'b1, k);
            chk(16'(k), 16'(bit_exp));
        end
    endtask : rate_case

    // A divisor write restarts the timer from zero, rewrites too.
    task automatic test_restart;
        int k;
        rate_case(8'h04, 8'hc8, 201, 3216);
        repeat (50) @(negedge clk);
        wr(2'h2, 8'h04);
        gap(1'b0, k);
        chk(16'(k), 16'h0006);
        gap(1'b0, k);
        chk(16'(k), 16'h0005);
        wr(2'h2, 8'h04);
        gap(1'b0, k);
        chk(16'(k), 16'h0006);
    endtask : test_restart

    // Majority vote rejects a single-sample spike but follows two samples.
    task automatic test_vote;
        int lows;
        rate_case(8'h04, 8'h00, 1, 16);
        @(posedge clk);
        level_req <= 1'b0;
        repeat (10) @(negedge clk);
        chk(16'(rx_level), 16'h0000);
        @(posedge clk);
        level_req <= 1'b1;
        @(posedge clk);
        level_req <= 1'b0;
        lows = 0;
        repeat (10) begin
            @(negedge clk);
            if (rx_level !== 1'b0) lows++;
        end
        chk(16'(lows), 16'h0000);
        @(posedge clk);
        level_req <= 1'b1;
        repeat (10) @(negedge clk);
        chk(16'(rx_level), 16'h0001);
        @(posedge clk);
        level_req <= 1'b0;
        repeat (2) @(posedge clk);
        level_req <= 1'b1;
        lows = 0;
        repeat (10) begin
            @(negedge clk);
            if (rx_level === 1'b0) lows++;
        end
        chk(16'(lows > 0), 16'h0001);
    endtask : test_vote

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        addr = '0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        tx_shift_empty = 1'b1;
        rx_stat = 3'b101;
        rx_single_done = 1'b0;
        level_req = 1'b1;
        mismatches = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        test_regs();
        rate_case(8'h00, 8'h03, 4, 256);
        rate_case(8'h04, 8'h02, 3, 48);
        rate_case(8'h94, 8'h05, 6, 24);
        rate_case(8'h90, 8'h05, 6, 24);
        rate_case(8'h14, 8'h05, 0, 0);
        wr(2'h1, 8'h00);
        no_ticks();
        test_restart();
        test_vote();
        close_out();
    end

    // The whole run needs some 8600 cycles; this limit leaves ample margin.
    initial begin
        #240000;
        mismatches++;
        close_out();
    end
endmodule : sbg_top_tb
`default_nettype wire
